// ===== dv/port_pin_model.sv
`timescale 1ns/1ps
module port_pin_model (
  // pin drive from the timer block
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  // resolved pad level
  output logic [1:0] pad
);
  // pull-up: an undriven pad reads high, never the last driven value
  assign pad = (pin_oe & pin_out) | ~pin_oe;
endmodule // port_pin_model

// ===== dv/timer8_compare_output_ctc_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module timer8_compare_output_ctc_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h1;
  logic [31:0] readdata;
  logic waitrequest;
  logic timer_tick = 1'b0;
  logic overflow_int_done = 1'b0;
  logic [1:0] compare_int_done = 2'h0;
  logic [1:0] port_latch = 2'h0;
  logic [1:0] port_dir = 2'h0;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic [1:0] pad;
  logic overflow_flag;
  logic [1:0] compare_flag;
  logic [31:0] exp_q[$];
  logic [31:0] exp_v;
  logic st = 1'b0;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 20;
  int n;

  always #25 mclk = ~mclk;

  timer8_compare_output_ctc u_timer8_compare_output_ctc (
    .mclk(mclk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .timer_tick(timer_tick), .overflow_int_done(overflow_int_done),
    .compare_int_done(compare_int_done), .port_latch(port_latch),
    .port_dir(port_dir), .pin_out(pin_out), .pin_oe(pin_oe),
    .overflow_flag(overflow_flag), .compare_flag(compare_flag)
  );

  port_pin_model u_port_pin_model (
    .pin_out(pin_out), .pin_oe(pin_oe), .pad(pad)
  );

  task results;
    $display("errors=%0d checks=%0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [7:0] d);
    @(posedge mclk);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= {24'h0, d};
    @(posedge mclk);
    while (waitrequest !== 1'b0) @(posedge mclk);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask

  task automatic tick(input int k);
    repeat (k) begin
      @(posedge mclk);
      timer_tick <= 1'b1;
    end
    @(posedge mclk);
    timer_tick <= 1'b0;
  endtask

  // read data checker; also cuts a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      results();
    end
    if (read && waitrequest === 1'b0) begin
      exp_v = exp_q.pop_front();
      `CHK(readdata, exp_v)
    end
  end

  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(timer8_pkg::OFF_CTRL_A, 8'h00);
    rd(timer8_pkg::OFF_FLAGS, 8'h00);
    wr_cnt: bus(1'b1, timer8_pkg::OFF_COUNT, 8'hfd);
    tick(3);
    #1;
    `CHK(overflow_flag, 1'b1)
    rd(timer8_pkg::OFF_COUNT, 8'h00);
    @(posedge mclk);
    overflow_int_done <= 1'b1;
    @(posedge mclk);
    overflow_int_done <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK(overflow_flag, 1'b0)
    $display("test normal wrap done");
    port_dir <= 2'b11;
    for (int m = 0; m < 4; m++) begin
      port_latch <= 2'($random(seed));
      bus(1'b1, timer8_pkg::OFF_CTRL_A, {m[1:0], 6'h00});
      bus(1'b1, timer8_pkg::OFF_CTRL_C, 8'h80);
      if (m == 1) st = ~st;
      else if (m > 1) st = m[0];
      rd(timer8_pkg::OFF_FLAGS, {3'h0, st, 4'h0});
      #1;
      `CHK(pin_out[0], (m == 0) ? port_latch[0] : st)
    end
    `CHK(pin_oe, 2'b11)
    port_dir <= 2'b00;
    repeat (2) @(posedge mclk);
    #1;
    `CHK(pad, 2'b11)
    $display("test force and override done");
    bus(1'b1, timer8_pkg::OFF_CTRL_A, 8'h42);
    bus(1'b1, timer8_pkg::OFF_CMP_A, 8'h02);
    bus(1'b1, timer8_pkg::OFF_COUNT, 8'h00);
    tick(3);
    rd(timer8_pkg::OFF_FLAGS, 8'h02);
    rd(timer8_pkg::OFF_COUNT, 8'h00);
    @(posedge mclk);
    compare_int_done <= 2'b01;
    @(posedge mclk);
    compare_int_done <= 2'b00;
    @(posedge mclk);
    #1;
    `CHK(compare_flag, 2'b00)
    // free-running ticks: one full toggle period in clocks
    port_dir <= 2'b01;
    @(posedge mclk);
    timer_tick <= 1'b1;
    n = 0;
    while (pin_out[0] !== 1'b1) @(posedge mclk);
    while (pin_out[0] !== 1'b0) begin
      @(posedge mclk);
      n++;
    end
    while (pin_out[0] !== 1'b1) begin
      @(posedge mclk);
      n++;
    end
    timer_tick <= 1'b0;
    `CHK(n, 6)
    $display("test ctc toggle done");
    bus(1'b1, timer8_pkg::OFF_FLAGS, 8'h07);
    bus(1'b1, timer8_pkg::OFF_COUNT, 8'h02);
    tick(1);
    #1;
    `CHK(compare_flag, 2'b00)
    rd(timer8_pkg::OFF_COUNT, 8'h03);
    // top below count: run past max and wrap before the match
    tick(253);
    #1;
    `CHK(overflow_flag, 1'b1)
    `CHK(compare_flag[0], 1'b0)
    tick(3);
    #1;
    `CHK(compare_flag[0], 1'b1)
    $display("test ctc block and wrap done");
    bus(1'b1, timer8_pkg::OFF_CTRL_A, 8'h32);
    bus(1'b1, timer8_pkg::OFF_CTRL_C, 8'h40);
    #1;
    `CHK(pin_out[1], 1'b1)
    bus(1'b1, timer8_pkg::OFF_CTRL_A, 8'h22);
    bus(1'b1, timer8_pkg::OFF_CTRL_C, 8'h40);
    #1;
    `CHK(pin_out[1], 1'b0)
    $display("test channel b force done");
    results();
  end
endmodule // timer8_compare_output_ctc_tb

// ===== verilog/compare_output_channel.sv
`timescale 1ns/1ps
module compare_output_channel (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic [1:0] mode,
  input wire logic hit,
  input wire logic force_hit,
  // port pin logic
  input wire logic port_latch,
  input wire logic port_dir,
  // outputs
  output logic state,
  output logic pin_out,
  output logic pin_oe
);

  logic state_reg;
  logic state_next;
  logic pin_out_reg;
  logic pin_out_next;
  logic pin_oe_reg;
  logic pin_oe_next;
  logic action;

  always_comb begin
    unique case (mode)
      timer8_pkg::COM_HOLD: action = state_reg;
      timer8_pkg::COM_TOGGLE: action = ~state_reg;
      timer8_pkg::COM_CLEAR: action = 1'b0;
      timer8_pkg::COM_SET: action = 1'b1;
    endcase
    // mode is read at the match itself, so a new mode acts on the next one
    state_next = (hit | force_hit) ? action : state_reg;
    // override depends on mode only, whatever the waveform mode is
    pin_out_next = (mode != timer8_pkg::COM_HOLD) ? state_next
                                                  : port_latch;
    pin_oe_next = port_dir;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= timer8_pkg::STATE_RST;
      pin_out_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  assign state = state_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;

  state_reset_a: assert property (@(posedge mclk)
    rst |=> state_reg == 1'b0) else $error("state not cleared by reset");
  mode_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (hit || force_hit) && mode == 2'h0 |=> $stable(state_reg))
    else $error("mode zero changed the output state");
  toggle_match_a: assert property (@(posedge mclk) disable iff (rst)
    (hit || force_hit) && mode == 2'h1 |=> state_reg != $past(state_reg))
    else $error("toggle mode did not toggle");
  pin_override_a: assert property (@(posedge mclk) disable iff (rst)
    mode != 2'h0 |=> pin_out_reg == state_reg)
    else $error("pin not driven from output state");
  pin_dir_a: assert property (@(posedge mclk) disable iff (rst)
    ##1 pin_oe_reg == $past(port_dir))
    else $error("pin direction not from port");

endmodule // compare_output_channel

// ===== verilog/timer8_compare_output_ctc.sv
`timescale 1ns/1ps
module timer8_compare_output_ctc (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // tick enable from prescaler
  input wire logic timer_tick,
  // interrupt executed strobes
  input wire logic overflow_int_done,
  input wire logic [1:0] compare_int_done,
  // general port pin logic
  input wire logic [1:0] port_latch,
  input wire logic [1:0] port_dir,
  // pins and flags
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic overflow_flag,
  output logic [1:0] compare_flag
);

  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_a_next;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] cmp_reg [2];
  logic [7:0] cmp_next [2];
  logic ovf_reg;
  logic ovf_next;
  logic [1:0] cflag_reg;
  logic [1:0] cflag_next;
  logic block_reg;
  logic block_next;
  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  logic [1:0] wgm;
  logic [1:0] com [2];
  logic non_pwm;
  logic wr_acc;
  logic wr_count;
  logic wr_flags;
  logic ctc_clear;
  logic ovf_set;
  logic [1:0] hit;
  logic [1:0] force_hit;
  logic [1:0] out_state;
  logic [1:0] clr_bits;
  int force_bit [2];
  int flag_bit [2];

  assign force_bit[0] = timer8_pkg::FORCE_A_BIT;
  assign force_bit[1] = timer8_pkg::FORCE_B_BIT;
  assign flag_bit[0] = timer8_pkg::CMP_A_BIT;
  assign flag_bit[1] = timer8_pkg::CMP_B_BIT;

  assign wgm = ctrl_a_reg[timer8_pkg::WGM_LSB +: 2];
  assign com[0] = ctrl_a_reg[timer8_pkg::COM_A_LSB +: 2];
  assign com[1] = ctrl_a_reg[timer8_pkg::COM_B_LSB +: 2];
  // pwm modes are not built; only normal and ctc count as non-pwm
  assign non_pwm = (wgm == timer8_pkg::WGM_NORMAL) ||
                   (wgm == timer8_pkg::WGM_CTC);

  // bus: a request is answered after one wait cycle
  always_comb begin
    wr_acc = write && !wait_reg && byteenable[0];
    wr_count = wr_acc && (address == timer8_pkg::OFF_COUNT);
    wr_flags = wr_acc && (address == timer8_pkg::OFF_FLAGS);
    wait_next = !((read || write) && wait_reg);
    rdata_next = rdata_reg;
    if (read && wait_reg) begin
      rdata_next = timer8_pkg::RDATA_NONE;
      unique case (address)
        timer8_pkg::OFF_CTRL_A: rdata_next[7:0] = ctrl_a_reg;
        timer8_pkg::OFF_COUNT: rdata_next[7:0] = count_reg;
        timer8_pkg::OFF_CMP_A: rdata_next[7:0] = cmp_reg[0];
        timer8_pkg::OFF_CMP_B: rdata_next[7:0] = cmp_reg[1];
        timer8_pkg::OFF_FLAGS: begin
          rdata_next[timer8_pkg::OVF_BIT] = ovf_reg;
          rdata_next[timer8_pkg::CMP_A_BIT] = cflag_reg[0];
          rdata_next[timer8_pkg::CMP_B_BIT] = cflag_reg[1];
          rdata_next[timer8_pkg::STATE_A_BIT] = out_state[0];
          rdata_next[timer8_pkg::STATE_B_BIT] = out_state[1];
        end
        // strobe register and holes read as zero
        default: rdata_next = timer8_pkg::RDATA_NONE;
      endcase
    end
  end

  // control and compare registers
  always_comb begin
    ctrl_a_next = ctrl_a_reg;
    cmp_next[0] = cmp_reg[0];
    cmp_next[1] = cmp_reg[1];
    if (wr_acc && address == timer8_pkg::OFF_CTRL_A) begin
      ctrl_a_next = writedata[7:0] & timer8_pkg::CTRL_A_MASK;
    end
    // compare values are unbuffered in these modes
    if (wr_acc && address == timer8_pkg::OFF_CMP_A) begin
      cmp_next[0] = writedata[7:0];
    end
    if (wr_acc && address == timer8_pkg::OFF_CMP_B) begin
      cmp_next[1] = writedata[7:0];
    end
  end

  // match detection per channel
  for (genvar i = 0; i < 2; i++) begin : g_chan
    always_comb begin
      // a match is only seen on a tick, and never on the first tick after a counter write
      hit[i] = timer_tick && !block_reg &&
               (count_reg == cmp_reg[i]);
      force_hit[i] = wr_acc && non_pwm &&
                     (address == timer8_pkg::OFF_CTRL_C) &&
                     writedata[force_bit[i]];
      clr_bits[i] = (wr_flags && writedata[flag_bit[i]]) ||
                    compare_int_done[i];
      // set wins over clear; a force never sets the flag
      cflag_next[i] = hit[i] || (cflag_reg[i] && !clr_bits[i]);
    end
    compare_output_channel u_chan (
      .mclk(mclk),
      .rst(rst),
      .mode(com[i]),
      .hit(hit[i]),
      .force_hit(force_hit[i]),
      .port_latch(port_latch[i]),
      .port_dir(port_dir[i]),
      .state(out_state[i]),
      .pin_out(pin_out[i]),
      .pin_oe(pin_oe[i])
    );
  end

  // counter; the output modes never enter here
  always_comb begin
    ctc_clear = (wgm == timer8_pkg::WGM_CTC) && hit[0];
    ovf_set = timer_tick && !wr_count &&
              (count_reg == timer8_pkg::COUNT_MAX);
    count_next = count_reg;
    if (wr_count) begin
      count_next = writedata[7:0];
    end else if (timer_tick) begin
      if (ctc_clear) begin
        count_next = timer8_pkg::COUNT_ZERO;
      end else begin
        // max plus one wraps to zero; normal mode never clears
        count_next = count_reg + 8'h01;
      end
    end
    // toggle period is 2*N*(1+top) since each half lasts top+1 ticks
    block_next = wr_count ? 1'b1 : (timer_tick ? 1'b0 : block_reg);
    ovf_next = ovf_set ||
               (ovf_reg && !overflow_int_done &&
                !(wr_flags && writedata[timer8_pkg::OVF_BIT]));
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_a_reg <= timer8_pkg::CTRL_A_RST;
      count_reg <= timer8_pkg::COUNT_ZERO;
      cmp_reg[0] <= timer8_pkg::CMP_RST;
      cmp_reg[1] <= timer8_pkg::CMP_RST;
      ovf_reg <= 1'b0;
      cflag_reg <= 2'h0;
      block_reg <= 1'b0;
      wait_reg <= 1'b1;
      rdata_reg <= timer8_pkg::RDATA_NONE;
    end else begin
      ctrl_a_reg <= ctrl_a_next;
      count_reg <= count_next;
      cmp_reg[0] <= cmp_next[0];
      cmp_reg[1] <= cmp_next[1];
      ovf_reg <= ovf_next;
      cflag_reg <= cflag_next;
      block_reg <= block_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign readdata = rdata_reg;
  assign waitrequest = wait_reg;
  assign overflow_flag = ovf_reg;
  assign compare_flag = cflag_reg;

  ovf_wrap_a: assert property (@(posedge mclk) disable iff (rst)
    timer_tick && !wr_count && count_reg == 8'hff && !overflow_int_done
    |=> ovf_reg && count_reg == 8'h00)
    else $error("overflow flag not set at wrap");
  normal_inc_a: assert property (@(posedge mclk) disable iff (rst)
    wgm == 2'h0 && timer_tick && !wr_count
    |=> count_reg == 8'($past(count_reg) + 8'h01))
    else $error("normal mode did not increment");
  ctc_clear_a: assert property (@(posedge mclk) disable iff (rst)
    wgm == 2'h2 && timer_tick && !block_reg && !wr_count &&
    count_reg == cmp_reg[0] |=> count_reg == 8'h00 && cflag_reg[0])
    else $error("ctc match did not clear counter and set flag");
  write_wins_a: assert property (@(posedge mclk) disable iff (rst)
    wr_count |=> count_reg == $past(writedata[7:0]) && block_reg)
    else $error("counter write lost");
  block_match_a: assert property (@(posedge mclk) disable iff (rst)
    block_reg && !cflag_reg[0] |=> !cflag_reg[0])
    else $error("blocked match set the flag");
  tick_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !timer_tick && !wr_count |=> $stable(count_reg))
    else $error("counter moved without a tick");
  force_flag_a: assert property (@(posedge mclk) disable iff (rst)
    force_hit[0] && !timer_tick && !cflag_reg[0]
    |=> !cflag_reg[0] && $stable(count_reg))
    else $error("force set flag or moved counter");
  bus_answer_a: assert property (@(posedge mclk) disable iff (rst)
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered in one wait cycle");

endmodule // timer8_compare_output_ctc

// ===== verilog/timer8_pkg.sv
package timer8_pkg;
  // register byte offsets on the bus
  localparam logic [4:0] OFF_CTRL_A = 5'h00;
  localparam logic [4:0] OFF_CTRL_C = 5'h04;
  localparam logic [4:0] OFF_COUNT = 5'h08;
  localparam logic [4:0] OFF_CMP_A = 5'h0c;
  localparam logic [4:0] OFF_CMP_B = 5'h10;
  localparam logic [4:0] OFF_FLAGS = 5'h14;
  // timer_ctrl_a fields
  localparam int WGM_LSB = 0;
  localparam int COM_B_LSB = 4;
  localparam int COM_A_LSB = 6;
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_A_MASK = 8'hf3;
  // timer_ctrl_c strobe bits
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  // flag register bits
  localparam int OVF_BIT = 0;
  localparam int CMP_A_BIT = 1;
  localparam int CMP_B_BIT = 2;
  localparam int STATE_A_BIT = 4;
  localparam int STATE_B_BIT = 5;
  // waveform_gen_mode codes
  localparam logic [1:0] WGM_NORMAL = 2'h0;
  localparam logic [1:0] WGM_CTC = 2'h2;
  // compare_output_mode codes
  localparam logic [1:0] COM_HOLD = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  // counter values and reset values
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic STATE_RST = 1'b0;
  localparam logic [31:0] RDATA_NONE = 32'h0000_0000;
endpackage
